//--- common/ple_pkg.sv
// Shared constants and types of the logic equation engine.
// Assumes one 50 MHz clock and an APB register port with 12-bit addresses.
`default_nettype none
package ple_pkg;
	// Operand sources
	localparam int NWIN = 8;
	localparam int NCON = 2;
	localparam int NANA = 2;
	localparam int NDIG = 2;
	localparam int NCNT = 2;
	localparam int NETM = 2;
	localparam int ETW = 1;
	localparam int NLAT = 8;
	localparam int LATW = 3;
	localparam int NSOFT = 8;
	localparam int NREM = 8;
	localparam int NDIR = 8;
	localparam int NVO = 8;
	localparam int VOW = 3;
	localparam int NTMR = NANA + NDIG + NETM;
	localparam int NSTEP = 32;
	localparam int PCW = 5;
	localparam int OPW = 7;
	localparam int NOPS = 128;
	localparam int DW = 16;
	// Operand index bases
	localparam int B_ZERO = 0;
	localparam int B_ONE = 1;
	localparam int B_WON = 2;
	localparam int B_WOFF = 10;
	localparam int B_CMON = 18;
	localparam int B_ANA = 26;
	localparam int B_DIG = 34;
	localparam int B_CNT = 40;
	localparam int B_SOFT = 46;
	localparam int B_REM = 54;
	localparam int B_DIR = 62;
	localparam int B_VO = 70;
	// Register byte addresses
	localparam logic [11:0] A_CTRL = 12'h000;
	localparam logic [11:0] A_STATUS = 12'h004;
	localparam logic [11:0] A_SOFT = 12'h008;
	localparam logic [11:0] A_VOUT = 12'h00c;
	localparam logic [11:0] A_ANA = 12'h010;
	localparam logic [11:0] A_CSET = 12'h018;
	localparam logic [11:0] A_CVAL = 12'h020;
	localparam logic [11:0] A_DSEL = 12'h028;
	localparam logic [11:0] A_TDLY = 12'h030;
	localparam logic [11:0] A_PROG = 12'h080;
	// Field positions
	localparam int F_RUN = 0;
	localparam int F_BUSY = 0;
	localparam int F_OVR = 1;
	localparam int F_PASS = 16;
	localparam int F_FALL = 16;
	localparam int F_RDLY = 16;
	localparam int F_OPC = 12;
	localparam int F_IDX = 8;
	// Reset values
	localparam logic CTRL_RUN_RST = 1'b1;
	localparam logic [15:0] PROG_RST = 16'h0000;
	// Pass timing: four passes in each 60 Hz cycle, rounded down
	localparam int CLK_MHZ = 50;
	localparam int SYS_CYCLE_US = 16666;
	localparam int PASSES_PER_CYCLE = 4;
	localparam int PASS_CYC = SYS_CYCLE_US * CLK_MHZ / PASSES_PER_CYCLE;

	typedef enum logic [3:0] {
		OP_END = 4'h0, OP_LOAD = 4'h1, OP_LOADN = 4'h2, OP_AND = 4'h3,
		OP_OR = 4'h4, OP_XOR = 4'h5, OP_ANDN = 4'h6, OP_ORN = 4'h7,
		OP_TIMER = 4'h8, OP_LATCH = 4'h9, OP_STORE = 4'ha
	} ple_opc_t;

	typedef enum logic {ST_IDLE, ST_RUN} ple_state_t;
endpackage : ple_pkg
`default_nettype wire

//--- common/ple_tmr_if.sv
// Link between the engine and one pickup/reset delay timer.
// Assumes the owner drives tick, level and both delays.
`default_nettype none
interface ple_tmr_if;
	logic tick;
	logic lvl;
	logic [15:0] pkp_dly;
	logic [15:0] rst_dly;
	logic op;
	modport ctl (output tick, output lvl, output pkp_dly, output rst_dly, input op);
	modport tmr (input tick, input lvl, input pkp_dly, input rst_dly, output op);
endinterface : ple_tmr_if
`default_nettype wire

//--- rtl/ple_timer.sv
// Pickup/reset delay timer counting pass ticks.
// Assumes tick is a one-cycle enable from the pass divider.
`default_nettype none
module ple_timer (
	input wire logic pclk,
	input wire logic presetn,
	ple_tmr_if.tmr bus
);
	logic [15:0] cnt_r;
	logic op_r;
	logic [15:0] dly;

	assign dly = bus.lvl ? bus.pkp_dly : bus.rst_dly;
	assign bus.op = op_r;

	// Any return of the level restarts the count from zero
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_r <= 16'h0000;
			op_r <= 1'b0;
		end else if (bus.lvl == op_r) begin
			cnt_r <= 16'h0000;
		end else if (dly == 16'h0000) begin
			op_r <= bus.lvl;
			cnt_r <= 16'h0000;
		end else if (bus.tick) begin
			if ({1'b0, cnt_r} + 17'h00001 >= {1'b0, dly}) begin
				op_r <= bus.lvl;
				cnt_r <= 16'h0000;
			end else begin
				cnt_r <= cnt_r + 16'h0001;
			end
		end
	end

	a_tmr_nodelay: assert property (@(posedge pclk) disable iff (!presetn)
		bus.lvl && !op_r && bus.pkp_dly == 16'h0000 |=> op_r)
		else $error("timer with zero pickup delay did not operate");
	// Between ticks the reset delay cannot run out, so operate must hold
	a_tmr_hold: assert property (@(posedge pclk) disable iff (!presetn)
		op_r && !bus.lvl && bus.rst_dly != 16'h0000 && !bus.tick |=> op_r)
		else $error("operate dropped before reset delay");
endmodule : ple_timer
`default_nettype wire

//--- rtl/ple_engine.sv
// Sequential logic equation engine with its operand sources and APB registers.
// Assumes a zero-wait APB master and inputs synchronous to pclk.
`default_nettype none
module ple_engine #(
	parameter int PASS_CYC = ple_pkg::PASS_CYC
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic pready,
	output logic [31:0] prdata,
	output logic pslverr,
	input wire logic [ple_pkg::NWIN-1:0] wired_in,
	input wire logic [ple_pkg::NCON-1:0] contact_v,
	input wire logic [ple_pkg::NCON-1:0] contact_i,
	input wire logic [ple_pkg::NANA-1:0][ple_pkg::DW-1:0] meas_val,
	input wire logic [ple_pkg::NANA-1:0] ana_block,
	input wire logic [ple_pkg::NCNT-1:0] cnt_pulse,
	input wire logic [ple_pkg::NREM-1:0] remote_in,
	input wire logic [ple_pkg::NDIR-1:0] direct_in,
	output logic [ple_pkg::NVO-1:0] vout
);
	function automatic logic addr_ok(input logic [11:0] a);
		return a[1:0] == 2'b00 && (a < ple_pkg::A_TDLY + 12'h018
			|| a[11:7] == ple_pkg::A_PROG[11:7]);
	endfunction : addr_ok

	function automatic logic [2:0] cnt_cmp(input logic [15:0] c, input logic [15:0] s);
		return {c > s, c == s, c < s};
	endfunction : cnt_cmp

	logic run_en_r, ovr_r;
	logic [7:0] pass_cnt_r;
	logic [ple_pkg::NSOFT-1:0] soft_r;
	logic [ple_pkg::NVO-1:0] vout_r;
	logic [16:0] ana_set_r [ple_pkg::NANA];
	logic [15:0] cset_r [ple_pkg::NCNT];
	logic [15:0] cval_r [ple_pkg::NCNT];
	logic [ple_pkg::OPW-1:0] dsel_r [ple_pkg::NDIG];
	logic [31:0] tdly_r [ple_pkg::NTMR];
	logic [15:0] prog_r [ple_pkg::NSTEP];
	logic [31:0] prdata_r, rdata_c, div_r;
	logic [ple_pkg::NANA-1:0] ana_pkp_r;
	logic [ple_pkg::NDIG-1:0] dig_pkp_r;
	logic [ple_pkg::NCNT-1:0] cpl_r;
	logic [ple_pkg::NETM-1:0] eqt_lvl_r;
	logic [ple_pkg::NLAT-1:0] lat_r;
	logic [ple_pkg::NTMR-1:0] tmr_op;
	logic [ple_pkg::NOPS-1:0] opv;
	logic [ple_pkg::PCW-1:0] pc_r;
	logic acc_r, acc_nxt, opnd, wr, tick, last, start;
	logic [15:0] ins;
	ple_pkg::ple_opc_t opc;
	ple_pkg::ple_state_t st_r;

	// APB slave: zero wait states, read data captured in the setup cycle
	assign pready = 1'b1;
	assign prdata = prdata_r;
	assign pslverr = psel && penable && !addr_ok(paddr);
	assign wr = psel && penable && pwrite && addr_ok(paddr);
	assign vout = vout_r;

	always_comb begin
		rdata_c = 32'h00000000;
		if (paddr[11:7] == ple_pkg::A_PROG[11:7]) begin
			rdata_c[15:0] = prog_r[paddr[6:2]];
		end else begin
			unique case (paddr[11:2])
				ple_pkg::A_CTRL[11:2]: rdata_c[ple_pkg::F_RUN] = run_en_r;
				ple_pkg::A_STATUS[11:2]: begin
					rdata_c[ple_pkg::F_BUSY] = st_r == ple_pkg::ST_RUN;
					rdata_c[ple_pkg::F_OVR] = ovr_r;
					rdata_c[ple_pkg::F_PASS +: 8] = pass_cnt_r;
				end
				ple_pkg::A_SOFT[11:2]: rdata_c[ple_pkg::NSOFT-1:0] = soft_r;
				ple_pkg::A_VOUT[11:2]: rdata_c[ple_pkg::NVO-1:0] = vout_r;
				ple_pkg::A_ANA[11:2]: rdata_c[16:0] = ana_set_r[0];
				ple_pkg::A_ANA[11:2] + 10'h001: rdata_c[16:0] = ana_set_r[1];
				ple_pkg::A_CSET[11:2]: rdata_c[15:0] = cset_r[0];
				ple_pkg::A_CSET[11:2] + 10'h001: rdata_c[15:0] = cset_r[1];
				ple_pkg::A_CVAL[11:2]: rdata_c[15:0] = cval_r[0];
				ple_pkg::A_CVAL[11:2] + 10'h001: rdata_c[15:0] = cval_r[1];
				ple_pkg::A_DSEL[11:2]: rdata_c[ple_pkg::OPW-1:0] = dsel_r[0];
				ple_pkg::A_DSEL[11:2] + 10'h001: rdata_c[ple_pkg::OPW-1:0] = dsel_r[1];
				default: begin
					if (paddr >= ple_pkg::A_TDLY && paddr < ple_pkg::A_TDLY + 12'h018) begin
						rdata_c = tdly_r[3'(paddr[4:2] - ple_pkg::A_TDLY[4:2])];
					end
				end
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_r <= 32'h00000000;
		end else if (psel && !penable && !pwrite) begin
			prdata_r <= rdata_c;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			run_en_r <= ple_pkg::CTRL_RUN_RST;
			soft_r <= '0;
			for (int i = 0; i < ple_pkg::NANA; i++) ana_set_r[i] <= 17'h00000;
			for (int i = 0; i < ple_pkg::NDIG; i++) dsel_r[i] <= 7'h00;
			for (int i = 0; i < ple_pkg::NCNT; i++) cset_r[i] <= 16'h0000;
			for (int i = 0; i < ple_pkg::NTMR; i++) tdly_r[i] <= 32'h00000000;
			for (int i = 0; i < ple_pkg::NSTEP; i++) prog_r[i] <= ple_pkg::PROG_RST;
		end else if (wr) begin
			if (paddr[11:7] == ple_pkg::A_PROG[11:7]) prog_r[paddr[6:2]] <= pwdata[15:0];
			if (paddr == ple_pkg::A_CTRL) run_en_r <= pwdata[ple_pkg::F_RUN];
			if (paddr == ple_pkg::A_SOFT) soft_r <= pwdata[ple_pkg::NSOFT-1:0];
			for (int i = 0; i < ple_pkg::NANA; i++)
				if (paddr == ple_pkg::A_ANA + 12'(4 * i)) ana_set_r[i] <= pwdata[16:0];
			for (int i = 0; i < ple_pkg::NDIG; i++)
				if (paddr == ple_pkg::A_DSEL + 12'(4 * i)) dsel_r[i] <= pwdata[6:0];
			for (int i = 0; i < ple_pkg::NCNT; i++)
				if (paddr == ple_pkg::A_CSET + 12'(4 * i)) cset_r[i] <= pwdata[15:0];
			for (int i = 0; i < ple_pkg::NTMR; i++)
				if (paddr == ple_pkg::A_TDLY + 12'(4 * i)) tdly_r[i] <= pwdata;
		end
	end

	// Pulse counters: rising edges counted, cleared when a new target is written
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cpl_r <= '0;
			for (int i = 0; i < ple_pkg::NCNT; i++) cval_r[i] <= 16'h0000;
		end else begin
			cpl_r <= cnt_pulse;
			for (int i = 0; i < ple_pkg::NCNT; i++) begin
				if (wr && paddr == ple_pkg::A_CSET + 12'(4 * i)) cval_r[i] <= 16'h0000;
				else if (cnt_pulse[i] && !cpl_r[i]) cval_r[i] <= cval_r[i] + 16'h0001;
			end
		end
	end

	// Element comparators, registered so an element cannot read itself in a loop
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ana_pkp_r <= '0;
			dig_pkp_r <= '0;
		end else begin
			for (int i = 0; i < ple_pkg::NANA; i++)
				ana_pkp_r[i] <= ana_set_r[i][ple_pkg::F_FALL]
					? meas_val[i] < ana_set_r[i][15:0]
					: meas_val[i] > ana_set_r[i][15:0];
			for (int i = 0; i < ple_pkg::NDIG; i++) dig_pkp_r[i] <= opv[dsel_r[i]];
		end
	end

	// Operand vector; unused indices read zero
	always_comb begin
		opv = '0;
		opv[ple_pkg::B_ZERO] = 1'b0;
		opv[ple_pkg::B_ONE] = 1'b1;
		for (int i = 0; i < ple_pkg::NWIN; i++) begin
			opv[ple_pkg::B_WON + i] = wired_in[i];
			opv[ple_pkg::B_WOFF + i] = !wired_in[i];
		end
		for (int i = 0; i < ple_pkg::NCON; i++) begin
			opv[ple_pkg::B_CMON + 4 * i] = contact_v[i];
			opv[ple_pkg::B_CMON + 4 * i + 1] = !contact_v[i];
			opv[ple_pkg::B_CMON + 4 * i + 2] = contact_i[i];
			opv[ple_pkg::B_CMON + 4 * i + 3] = !contact_i[i];
		end
		for (int i = 0; i < ple_pkg::NANA; i++) begin
			opv[ple_pkg::B_ANA + 4 * i] = ana_pkp_r[i];
			opv[ple_pkg::B_ANA + 4 * i + 1] = !ana_pkp_r[i];
			opv[ple_pkg::B_ANA + 4 * i + 2] = tmr_op[i];
			opv[ple_pkg::B_ANA + 4 * i + 3] = ana_block[i];
		end
		for (int i = 0; i < ple_pkg::NDIG; i++) begin
			opv[ple_pkg::B_DIG + 3 * i] = dig_pkp_r[i];
			opv[ple_pkg::B_DIG + 3 * i + 1] = !dig_pkp_r[i];
			opv[ple_pkg::B_DIG + 3 * i + 2] = tmr_op[ple_pkg::NANA + i];
		end
		for (int i = 0; i < ple_pkg::NCNT; i++)
			opv[ple_pkg::B_CNT + 3 * i +: 3] = cnt_cmp(cval_r[i], cset_r[i]);
		opv[ple_pkg::B_SOFT +: ple_pkg::NSOFT] = soft_r;
		opv[ple_pkg::B_REM +: ple_pkg::NREM] = remote_in;
		opv[ple_pkg::B_DIR +: ple_pkg::NDIR] = direct_in;
		opv[ple_pkg::B_VO +: ple_pkg::NVO] = vout_r;
	end

	// Delay timers: analog elements, digital elements, then equation timers
	ple_tmr_if tif [ple_pkg::NTMR] ();
	for (genvar g = 0; g < ple_pkg::NTMR; g++) begin : g_tmr
		assign tif[g].tick = tick;
		assign tif[g].pkp_dly = tdly_r[g][15:0];
		assign tif[g].rst_dly = tdly_r[g][ple_pkg::F_RDLY +: 16];
		if (g < ple_pkg::NANA) begin : g_ana
			assign tif[g].lvl = ana_pkp_r[g];
		end else if (g < ple_pkg::NANA + ple_pkg::NDIG) begin : g_dig
			assign tif[g].lvl = dig_pkp_r[g - ple_pkg::NANA];
		end else begin : g_eq
			assign tif[g].lvl = eqt_lvl_r[g - ple_pkg::NANA - ple_pkg::NDIG];
		end
		assign tmr_op[g] = tif[g].op;
		ple_timer u_tmr (
			.pclk(pclk),
			.presetn(presetn),
			.bus(tif[g])
		);
	end

	// Pass divider: one tick per quarter of a power-system cycle
	assign tick = div_r == 32'(PASS_CYC - 1);
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) div_r <= 32'h00000000;
		else div_r <= tick ? 32'h00000000 : div_r + 32'h00000001;
	end

	assign ins = prog_r[pc_r];
	assign opc = ple_pkg::ple_opc_t'(ins[ple_pkg::F_OPC +: 4]);
	assign opnd = opv[ins[ple_pkg::OPW-1:0]];
	assign last = opc == ple_pkg::OP_END || pc_r == ple_pkg::PCW'(ple_pkg::NSTEP - 1);
	assign start = st_r == ple_pkg::ST_IDLE && tick && run_en_r;

	always_comb begin
		unique case (opc)
			ple_pkg::OP_LOAD: acc_nxt = opnd;
			ple_pkg::OP_LOADN: acc_nxt = !opnd;
			ple_pkg::OP_AND: acc_nxt = acc_r & opnd;
			ple_pkg::OP_OR: acc_nxt = acc_r | opnd;
			ple_pkg::OP_XOR: acc_nxt = acc_r ^ opnd;
			ple_pkg::OP_ANDN: acc_nxt = acc_r & !opnd;
			ple_pkg::OP_ORN: acc_nxt = acc_r | !opnd;
			ple_pkg::OP_TIMER: acc_nxt = tmr_op[ple_pkg::NANA + ple_pkg::NDIG
				+ int'(ins[ple_pkg::F_IDX +: ple_pkg::ETW])];
			ple_pkg::OP_LATCH: acc_nxt = acc_r
				| (lat_r[ins[ple_pkg::F_IDX +: ple_pkg::LATW]] & !opnd);
			default: acc_nxt = acc_r;
		endcase
	end

	// Sequencer: a pass starts on the tick and walks the program one step a cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_r <= ple_pkg::ST_IDLE;
			pc_r <= '0;
			acc_r <= 1'b0;
			pass_cnt_r <= 8'h00;
		end else if (start) begin
			st_r <= ple_pkg::ST_RUN;
			pc_r <= '0;
			acc_r <= 1'b0;
		end else if (st_r == ple_pkg::ST_RUN) begin
			acc_r <= acc_nxt;
			pc_r <= pc_r + ple_pkg::PCW'(1);
			if (last) begin
				st_r <= ple_pkg::ST_IDLE;
				pass_cnt_r <= pass_cnt_r + 8'h01;
			end
		end
	end

	// Stores update in place, so earlier results are current and later ones are old
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			vout_r <= '0;
			lat_r <= '0;
			eqt_lvl_r <= '0;
		end else if (st_r == ple_pkg::ST_RUN) begin
			if (opc == ple_pkg::OP_STORE)
				vout_r[ins[ple_pkg::F_IDX +: ple_pkg::VOW]] <= acc_r;
			if (opc == ple_pkg::OP_LATCH)
				lat_r[ins[ple_pkg::F_IDX +: ple_pkg::LATW]] <= acc_nxt;
			if (opc == ple_pkg::OP_TIMER)
				eqt_lvl_r[ins[ple_pkg::F_IDX +: ple_pkg::ETW]] <= acc_r;
		end
	end

	// Overrun: a tick while a pass still runs; set wins over the write-one clear
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) ovr_r <= 1'b0;
		else if (tick && st_r == ple_pkg::ST_RUN) ovr_r <= 1'b1;
		else if (wr && paddr == ple_pkg::A_STATUS && pwdata[ple_pkg::F_OVR]) ovr_r <= 1'b0;
	end

	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);

	logic [31:0] since_r;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) since_r <= 32'h00000000;
		else if (start || !run_en_r) since_r <= 32'h00000000;
		else if (since_r != 32'hffffffff) since_r <= since_r + 32'h00000001;
	end

	a_pass_rate: assert property (run_en_r |-> since_r <= 32'(PASS_CYC))
		else $error("pass interval exceeded");
	a_pass_start: assert property (start |=> st_r == ple_pkg::ST_RUN && pc_r == '0)
		else $error("pass did not start at step zero");
	a_step_order: assert property (st_r == ple_pkg::ST_RUN && !last
		|=> pc_r == $past(pc_r) + ple_pkg::PCW'(1))
		else $error("steps not taken in order");
	a_store_flag: assert property (st_r == ple_pkg::ST_RUN && opc == ple_pkg::OP_STORE
		|=> vout[$past(ins[ple_pkg::F_IDX +: ple_pkg::VOW])] == $past(acc_r))
		else $error("result flag does not hold stored value");
	a_const_ops: assert property (opv[ple_pkg::B_ONE] && !opv[ple_pkg::B_ZERO])
		else $error("constant operands wrong");
	a_ana_pickup: assert property (ana_set_r[0] == $past(ana_set_r[0])
		&& meas_val[0] > ana_set_r[0][15:0] && !ana_set_r[0][ple_pkg::F_FALL]
		|=> opv[ple_pkg::B_ANA] && !opv[ple_pkg::B_ANA + 1])
		else $error("rising pickup or dropout wrong");
	a_cnt_onehot: assert property ($onehot(opv[ple_pkg::B_CNT +: 3]))
		else $error("counter flags not exclusive");
	a_soft_follow: assert property (wr && paddr == ple_pkg::A_SOFT
		|=> opv[ple_pkg::B_SOFT +: ple_pkg::NSOFT] == $past(pwdata[ple_pkg::NSOFT-1:0]))
		else $error("soft input flags do not follow write");
	a_wired_pair: assert property (opv[ple_pkg::B_WON] == wired_in[0]
		&& opv[ple_pkg::B_WOFF] == !wired_in[0])
		else $error("wired input flags wrong");

	c_pass_done: cover property (st_r == ple_pkg::ST_RUN && last && pc_r != '0);
	c_store_one: cover property (st_r == ple_pkg::ST_RUN && opc == ple_pkg::OP_STORE && acc_r);
	c_overrun: cover property (tick && st_r == ple_pkg::ST_RUN);
endmodule : ple_engine
`default_nettype wire

//--- testbench/ple_partner.sv
// Model of the relay side feeding the engine: wired inputs, contacts, elements, links.
// Assumes the bench commands every level through the tasks below.
`default_nettype none
module ple_partner (
	input wire logic pclk,
	output logic [ple_pkg::NWIN-1:0] wired_in,
	output logic [ple_pkg::NCON-1:0] contact_v,
	output logic [ple_pkg::NCON-1:0] contact_i,
	output logic [ple_pkg::NANA-1:0][ple_pkg::DW-1:0] meas_val,
	output logic [ple_pkg::NANA-1:0] ana_block,
	output logic [ple_pkg::NCNT-1:0] cnt_pulse,
	output logic [ple_pkg::NREM-1:0] remote_in,
	output logic [ple_pkg::NDIR-1:0] direct_in
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		wired_in = '0;
		contact_v = '0;
		contact_i = '0;
		meas_val = '0;
		ana_block = '0;
		cnt_pulse = '0;
		remote_in = '0;
		direct_in = '0;
	end
	// Levels change together just after an edge, as the real inputs are resampled
	task set_lvl(input logic [7:0] w, input logic [1:0] cv, input logic [1:0] ci,
		input logic [15:0] m0, input logic [1:0] block_flag, input logic [7:0] rem,
		input logic [7:0] dir);
		@(posedge pclk);
		wired_in <= w;
		contact_v <= cv;
		contact_i <= ci;
		meas_val[0] <= m0;
		ana_block <= block_flag;
		remote_in <= rem;
		direct_in <= dir;
	endtask : set_lvl
	// High for one cycle, then low, so each call gives exactly one rising edge
	task pulse(input int k);
		@(posedge pclk);
		cnt_pulse[k] <= 1'b1;
		@(posedge pclk);
		cnt_pulse[k] <= 1'b0;
	endtask : pulse
endmodule : ple_partner
`default_nettype wire

//--- testbench/ple_engine_tb.sv
// Self-checking bench of the logic equation engine over APB.
// Assumes a short pass period so that many passes fit in one run.
`default_nettype none
module ple_engine_tb;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [3:0] LD = ple_pkg::OP_LOAD;
	localparam logic [3:0] LN = ple_pkg::OP_LOADN;
	localparam logic [3:0] AN = ple_pkg::OP_AND;
	localparam logic [3:0] OR = ple_pkg::OP_OR;
	localparam logic [3:0] XR = ple_pkg::OP_XOR;
	localparam logic [3:0] NA = ple_pkg::OP_ANDN;
	localparam logic [3:0] NO = ple_pkg::OP_ORN;
	localparam logic [3:0] TM = ple_pkg::OP_TIMER;
	localparam logic [3:0] LT = ple_pkg::OP_LATCH;
	localparam logic [3:0] ST = ple_pkg::OP_STORE;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h00000000;
	logic pready;
	logic pslverr;
	logic [31:0] prdata;
	logic [7:0] wired_in, remote_in, direct_in, vout;
	logic [1:0] contact_v, contact_i, ana_block, cnt_pulse;
	logic [1:0][15:0] meas_val;
	logic [31:0] rd;
	logic er;
	logic v5;
	logic [15:0] prg [$];
	int ops [8];
	int error_cnt = 0;
	int n_checks = 0;
	int cyc = 0;

	ple_engine #(.PASS_CYC(64)) uut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
		.prdata(prdata), .pslverr(pslverr), .wired_in(wired_in), .contact_v(contact_v),
		.contact_i(contact_i), .meas_val(meas_val), .ana_block(ana_block),
		.cnt_pulse(cnt_pulse), .remote_in(remote_in), .direct_in(direct_in), .vout(vout));
	ple_partner partner (.pclk(pclk), .wired_in(wired_in), .contact_v(contact_v),
		.contact_i(contact_i), .meas_val(meas_val), .ana_block(ana_block),
		.cnt_pulse(cnt_pulse), .remote_in(remote_in), .direct_in(direct_in));

	always #10 pclk = ~pclk;

	task give_verdict;
		$display("checks %0d errors %0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : give_verdict

	// Run length is about 36 passes of 64 cycles plus bus traffic
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			error_cnt++;
			give_verdict();
		end
	end

	task fail(input string m);
		error_cnt++;
		$display("[FAIL] %0t %s", $time, m);
	endtask : fail

	task chk(input logic [31:0] g, input logic [31:0] e);
		n_checks++;
		if (g !== e)
			fail($sformatf("got %h exp %h", g, e));
	endtask : chk

	task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (n >= 20)
			fail("no ready");
	endtask : apb

	// A pass has ended once the pass count moved and busy is low again
	task wait_pass(input int k);
		logic [7:0] c0;
		int n;
		repeat (k) begin
			apb(1'b0, ple_pkg::A_STATUS, 32'h0);
			c0 = rd[23:16];
			n = 0;
			do begin
				apb(1'b0, ple_pkg::A_STATUS, 32'h0);
				n++;
			end while ((rd[23:16] === c0 || rd[0] !== 1'b0) && n < 60);
			if (n >= 60)
				fail("pass missing");
		end
	endtask : wait_pass

	function automatic logic [15:0] w(input logic [3:0] o, input int i, input int x);
		return {o, 1'b0, i[2:0], 1'b0, x[6:0]};
	endfunction : w

	task load;
		for (int i = 0; i < ple_pkg::NSTEP; i++) begin
			apb(1'b1, 12'(ple_pkg::A_PROG + 4 * i), (i < prg.size()) ? 32'(prg[i]) : 32'h0);
		end
	endtask : load

	task vchk(input logic [7:0] m, input logic [7:0] e);
		@(posedge pclk);
		chk({24'h0, vout & m}, {24'h0, e});
	endtask : vchk

	initial begin
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		vchk(8'hff, 8'h00);
		apb(1'b0, ple_pkg::A_CTRL, 32'h0);
		chk(rd, 32'h1);
		apb(1'b0, ple_pkg::A_PROG, 32'h0);
		chk(rd, 32'h0);
		apb(1'b0, 12'h070, 32'h0);
		chk({rd[30:0], er}, 32'h1);
		// Gates, constants, latch, feedback, equation timer and the wired, soft, remote, direct and contact operands
		apb(1'b1, 12'(ple_pkg::A_TDLY + 16), 32'h0);
		partner.set_lvl(8'h01, 2'b01, 2'b00, 16'd0, 2'b00, 8'h00, 8'h01);
		apb(1'b1, ple_pkg::A_SOFT, 32'h05);
		prg = '{w(LD, 0, ple_pkg::B_ONE), w(TM, 0, 0), w(ST, 0, 0),
			w(LD, 0, ple_pkg::B_ZERO), w(NO, 0, ple_pkg::B_ONE), w(ST, 1, 0),
			w(LD, 0, ple_pkg::B_WON), w(AN, 0, ple_pkg::B_SOFT), w(ST, 2, 0),
			w(LD, 0, ple_pkg::B_WOFF), w(OR, 0, ple_pkg::B_REM), w(ST, 3, 0),
			w(LN, 0, ple_pkg::B_DIR), w(XR, 0, ple_pkg::B_SOFT + 1), w(ST, 4, 0),
			w(LD, 0, ple_pkg::B_VO), w(NA, 0, ple_pkg::B_VO + 5), w(ST, 5, 0),
			w(LD, 0, ple_pkg::B_SOFT + 2), w(LT, 0, ple_pkg::B_SOFT + 3), w(ST, 6, 0),
			w(LD, 0, ple_pkg::B_CMON), w(AN, 0, ple_pkg::B_CMON + 3), w(ST, 7, 0)};
		load();
		wait_pass(2);
		vchk(8'hdf, 8'hc5);
		apb(1'b0, ple_pkg::A_VOUT, 32'h0);
		chk(rd & 32'hdf, 32'hc5);
		v5 = vout[5];
		wait_pass(1);
		vchk(8'h20, {~v5, 5'h0});
		wait_pass(1);
		vchk(8'h20, {v5, 5'h0});
		partner.set_lvl(8'h00, 2'b01, 2'b01, 16'd0, 2'b00, 8'h00, 8'h01);
		apb(1'b1, ple_pkg::A_SOFT, 32'h02);
		wait_pass(2);
		vchk(8'hdf, 8'h59);
		apb(1'b1, ple_pkg::A_SOFT, 32'h08);
		wait_pass(2);
		vchk(8'hdf, 8'h09);
		// Analog, counter and digital element operands
		// Counter flags sit below, equal, above from the base index upward
		ops = '{ple_pkg::B_ANA, ple_pkg::B_ANA + 1, ple_pkg::B_ANA + 3, ple_pkg::B_CNT + 2,
			ple_pkg::B_CNT + 1, ple_pkg::B_CNT, ple_pkg::B_ANA + 2, ple_pkg::B_DIG};
		prg = {};
		for (int k = 0; k < 8; k++) begin
			prg.push_back(w(LD, 0, ops[k]));
			prg.push_back(w(ST, k, 0));
		end
		apb(1'b1, ple_pkg::A_ANA, 32'd100);
		apb(1'b1, ple_pkg::A_TDLY, {16'd8, 16'd8});
		apb(1'b1, ple_pkg::A_CSET, 32'd2);
		apb(1'b1, ple_pkg::A_DSEL, 32'(ple_pkg::B_SOFT + 4));
		apb(1'b1, 12'(ple_pkg::A_TDLY + 8), 32'h0);
		apb(1'b1, ple_pkg::A_SOFT, 32'h00);
		partner.set_lvl(8'h00, 2'b00, 2'b00, 16'd50, 2'b00, 8'h00, 8'h00);
		load();
		wait_pass(2);
		vchk(8'hff, 8'h22);
		partner.set_lvl(8'h00, 2'b00, 2'b00, 16'd150, 2'b01, 8'h00, 8'h00);
		partner.pulse(0);
		partner.pulse(0);
		apb(1'b1, ple_pkg::A_SOFT, 32'h10);
		wait_pass(2);
		vchk(8'hff, 8'h95);
		apb(1'b0, ple_pkg::A_CVAL, 32'h0);
		chk(rd, 32'd2);
		wait_pass(10);
		vchk(8'hff, 8'hd5);
		partner.set_lvl(8'h00, 2'b00, 2'b00, 16'd50, 2'b01, 8'h00, 8'h00);
		partner.pulse(0);
		wait_pass(2);
		vchk(8'hff, 8'hce);
		wait_pass(10);
		vchk(8'hff, 8'h8e);
		apb(1'b1, ple_pkg::A_ANA, 32'h00010064);
		wait_pass(2);
		vchk(8'h03, 8'h01);
		apb(1'b0, ple_pkg::A_STATUS, 32'h0);
		chk(rd & 32'h2, 32'h0);
		give_verdict();
	end
endmodule : ple_engine_tb
`default_nettype wire
